/* File: rtl/led_sink_pkg.sv */
// constants and carrier types for the led sink shift/latch block
// Operation
// - shift register advances on each shift clock rise
// - serial input enters the first stage
// - latches transparent while strobe is high
// - undriven strobe reads low, latches hold (not modelled: the latch_strobe input has no pull-down)
// - enable low drives sinks from latched bits
// - enable high blanks every sink channel
// - undriven enable reads high, sinks blanked (not modelled: the channel_enable_n input has no pull-up)
// - strobe and enable also select special modes
// - serial chain output carries shifted-out data
// - shift register and latch sixteen bits wide
// - one error bit per channel recorded
package led_sink_pkg;

  // ------------------------------------------------------------
  // sizes and reset values
  // ------------------------------------------------------------
  localparam int          CHANNELS      = 16;
  localparam logic [15:0] SHIFT_RESET   = 16'h0000;
  localparam logic [15:0] LATCH_RESET   = 16'h0000;
  localparam logic [15:0] SINK_OFF      = 16'h0000;
  localparam logic [15:0] ERROR_RESET   = 16'h0000;
  localparam logic [1:0]  MODE_SEQ_LEN  = 2'h3;

  // ------------------------------------------------------------
  // operating modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL  = 2'b00,
    MODE_ERR_DET = 2'b01,
    MODE_CUR_ADJ = 2'b10
  } op_mode_e;

  // ------------------------------------------------------------
  // control pins as one carrier
  // ------------------------------------------------------------
  typedef struct packed {
    logic shift_clk;
    logic serial_in;
    logic latch_strobe;
    logic channel_enable_n;
  } ctrl_pins_s;

endpackage

/* File: rtl/led_sink_edge.sv */
// rising and falling edge detector for one sampled pin
`timescale 1ns/1ps
`default_nettype none
module led_sink_edge (
  // clock, reset, enable
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  // pin and edges
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic prev_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prev_q <= 1'b0;
    end else if (clk_en) begin
      prev_q <= pin;
    end
  end

  assign rise = clk_en & pin & ~prev_q;
  assign fall = clk_en & ~pin & prev_q;
endmodule
`default_nettype wire

/* File: rtl/led_sink_serial_shift_latch.sv */
// sixteen channel serial-in parallel-out sink driver control logic
`timescale 1ns/1ps
`default_nettype none
module led_sink_serial_shift_latch (
  // clock, reset, enable
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire logic                    clk_en,
  // control pins, synchronous to sys_clk
  input  wire led_sink_pkg::ctrl_pins_s pins,
  // per channel fault sense
  input  wire logic [15:0]             fault_sense,
  // outputs
  output logic [15:0]                  sink_channels,
  output logic                         serial_chain_out,
  output logic [1:0]                   mode,
  output logic [15:0]                  error_bits
);
  import led_sink_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [15:0] latch_q;
  logic [15:0] latch_d;
  logic [15:0] sink_q;
  logic [15:0] sink_d;
  logic [15:0] err_q;
  logic [15:0] err_d;
  logic        sdo_q;
  logic [1:0]  seq_cnt_q;
  logic [1:0]  seq_cnt_d;
  op_mode_e    mode_q;
  op_mode_e    mode_d;

  // ------------------------------------------------------------
  // edge detection of shift clock and strobe
  // ------------------------------------------------------------
  logic sclk_rise;
  logic le_rise;
  logic le_fall;

  led_sink_edge u_sclk_edge (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .pin     (pins.shift_clk),
    .rise    (sclk_rise),
    .fall    ()
  );

  led_sink_edge u_le_edge (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .pin     (pins.latch_strobe),
    .rise    (le_rise),
    .fall    (le_fall)
  );

  // ------------------------------------------------------------
  // datapath decode
  // ------------------------------------------------------------
  wire shift_now = sclk_rise;
  wire oe_on     = ~pins.channel_enable_n;
  wire seq_arm   = pins.channel_enable_n & pins.latch_strobe;
  wire seq_step  = sclk_rise & seq_arm;

  // first stage takes serial input
  assign shift_d = shift_now ? {shift_q[14:0], pins.serial_in}
                             : shift_q;
  // transparent while high, frozen once low
  assign latch_d = pins.latch_strobe ? shift_d : latch_q;
  // blank unless enable is low
  assign sink_d  = oe_on ? latch_d : SINK_OFF;

  // three shift clock rises with enable and strobe both held high pick a
  // mode; the count holds between rises, since a rise needs a low sample
  assign seq_cnt_d = ~seq_arm ? 2'h0
                   : ~seq_step ? seq_cnt_q
                   : (seq_cnt_q == MODE_SEQ_LEN) ? seq_cnt_q
                   : seq_cnt_q + 2'h1;

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_NORMAL: begin
        if (seq_step && seq_cnt_q == MODE_SEQ_LEN - 2'h1) begin
          mode_d = pins.serial_in ? MODE_CUR_ADJ : MODE_ERR_DET;
        end
      end
      MODE_ERR_DET: begin
        if (le_fall) begin
          mode_d = MODE_NORMAL;
        end
      end
      MODE_CUR_ADJ: begin
        if (le_fall) begin
          mode_d = MODE_NORMAL;
        end
      end
      default: begin
        mode_d = MODE_NORMAL;
      end
    endcase
  end

  // error capture: one bit per channel, only driven channels
  wire err_cap = (mode_q == MODE_ERR_DET) & oe_on;
  assign err_d = err_cap ? (fault_sense & latch_q) : err_q;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // shift register and chain output
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shift_q <= SHIFT_RESET;
      sdo_q   <= 1'b0;
    end else if (clk_en) begin
      shift_q <= shift_d;
      sdo_q   <= shift_d[CHANNELS-1];
    end
  end

  // output latch and registered sinks
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      latch_q <= LATCH_RESET;
      sink_q  <= SINK_OFF;
    end else if (clk_en) begin
      latch_q <= latch_d;
      sink_q  <= sink_d;
    end
  end

  // error register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      err_q <= ERROR_RESET;
    end else if (clk_en) begin
      err_q <= err_d;
    end
  end

  // mode sequence counter and mode state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seq_cnt_q <= 2'h0;
      mode_q    <= MODE_NORMAL;
    end else if (clk_en) begin
      seq_cnt_q <= seq_cnt_d;
      mode_q    <= mode_d;
    end
  end

  assign sink_channels    = sink_q;
  assign serial_chain_out = sdo_q;
  assign mode             = mode_q;
  assign error_bits       = err_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_sclk_low;
    clk_en && !pins.shift_clk;
  endsequence

  sequence s_sclk_high;
    clk_en && pins.shift_clk;
  endsequence

  // third counted rise while the mode sequence is armed
  sequence s_third_rise;
    mode_q == MODE_NORMAL && seq_step && seq_cnt_q == MODE_SEQ_LEN - 2'h1;
  endsequence

  a_shift_one_bit: assert property (
    @(posedge sys_clk) disable iff (reset)
    s_sclk_low ##1 s_sclk_high |=> shift_q[15:1] == $past(shift_q[14:0]))
    else $error("shift register did not advance");

  a_first_stage_in: assert property (
    @(posedge sys_clk) disable iff (reset)
    sclk_rise |=> shift_q[0] == $past(pins.serial_in))
    else $error("first stage missed serial input");

  a_latch_transp: assert property (
    @(posedge sys_clk) disable iff (reset)
    clk_en && pins.latch_strobe |=> latch_q == $past(shift_d))
    else $error("latch not transparent");

  a_latch_hold: assert property (
    @(posedge sys_clk) disable iff (reset)
    !pins.latch_strobe |=> $stable(latch_q))
    else $error("latch changed while strobe low");

  a_sink_blank: assert property (
    @(posedge sys_clk) disable iff (reset)
    clk_en && pins.channel_enable_n |=> sink_channels == SINK_OFF)
    else $error("sinks not blanked");

  a_sink_drive: assert property (
    @(posedge sys_clk) disable iff (reset)
    clk_en && !pins.channel_enable_n |=> sink_channels == latch_q)
    else $error("sinks do not follow latch");

  a_chain_last: assert property (
    @(posedge sys_clk) disable iff (reset)
    clk_en |=> serial_chain_out == shift_q[15])
    else $error("chain output not last stage");

  a_chain_shift: assert property (
    @(posedge sys_clk) disable iff (reset)
    sclk_rise |=> serial_chain_out == $past(shift_q[14]))
    else $error("chain output missed shifted bit");

  a_err_masked: assert property (
    @(posedge sys_clk) disable iff (reset)
    mode_q == MODE_NORMAL && clk_en |=> $stable(error_bits))
    else $error("error bits moved in normal mode");

  a_err_capture: assert property (
    @(posedge sys_clk) disable iff (reset)
    clk_en && err_cap |=> error_bits == $past(fault_sense & latch_q))
    else $error("error bits not captured");

  a_mode_entry: assert property (
    @(posedge sys_clk) disable iff (reset)
    s_third_rise |=> mode_q == ($past(pins.serial_in) ? MODE_CUR_ADJ
                                                     : MODE_ERR_DET))
    else $error("mode not entered on third rise");

  a_count_clear: assert property (
    @(posedge sys_clk) disable iff (reset)
    clk_en && !seq_arm |=> seq_cnt_q == 2'h0)
    else $error("mode counter not cleared");

  a_mode_exit: assert property (
    @(posedge sys_clk) disable iff (reset)
    mode_q != MODE_NORMAL && le_fall |=> mode_q == MODE_NORMAL)
    else $error("mode not left on strobe fall");
endmodule
`default_nettype wire

/* File: bench/led_host_model.sv */
// host controller model driving the sink driver control pins
`timescale 1ns/1ps
`default_nettype none
module led_host_model (
  // clock
  input  wire logic               sys_clk,
  // control pins
  output led_sink_pkg::ctrl_pins_s pins
);
  // -----------------------------------------------------------
  // pin defaults and transfers
  // -----------------------------------------------------------
  initial pins = {1'b0, 1'b0, 1'b0, 1'b1};
  task automatic shift_bits(input logic [15:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge sys_clk);
      pins.serial_in <= w[i];
      pins.shift_clk <= 1'b0;
      @(posedge sys_clk);
      pins.shift_clk <= 1'b1;
    end
    @(posedge sys_clk);
    pins.shift_clk <= 1'b0;
    pins.serial_in <= ~pins.serial_in;
  endtask
  task automatic set_pins(input logic strobe, input logic enable_n);
    @(posedge sys_clk);
    pins.latch_strobe     <= strobe;
    pins.channel_enable_n <= enable_n;
  endtask
  task automatic enter_mode(input logic pick);
    set_pins(1'b1, 1'b1);
    shift_bits({15'h0000, pick}, 3);
  endtask
  task automatic pulse_strobe();
    @(posedge sys_clk);
    pins.latch_strobe <= 1'b1;
    @(posedge sys_clk);
    pins.latch_strobe <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the sink driver shift/latch block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                     sys_clk = 1'b0;
  logic                     reset = 1'b1;
  logic                     clk_en = 1'b1;
  logic [15:0]              fault_sense = 16'h00FF;
  logic [15:0]              sink_channels;
  logic                     serial_chain_out;
  logic [1:0]               mode;
  logic [15:0]              error_bits;
  int                       bad_count = 0;
  int                       comparisons = 0;
  led_sink_pkg::ctrl_pins_s pins;
  always #20 sys_clk = ~sys_clk;
  led_host_model i_host (.sys_clk(sys_clk), .pins(pins));
  led_sink_serial_shift_latch i_dut (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .pins(pins),
    .fault_sense(fault_sense), .sink_channels(sink_channels),
    .serial_chain_out(serial_chain_out), .mode(mode),
    .error_bits(error_bits));
  // -----------------------------------------------------------
  // checking and verdict
  // -----------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_reset_state();
    @(posedge sys_clk);
    #1;
    check(sink_channels, 16'h0000);
    check({15'h0000, serial_chain_out}, 16'h0000);
    check({14'h0000, mode}, 16'h0000);
    check(error_bits, 16'h0000);
  endtask
  task automatic t_load_word();
    i_host.set_pins(1'b0, 1'b0);
    i_host.shift_bits(16'hA5C3, 16);
    #1;
    check(sink_channels, 16'h0000);
    check({15'h0000, serial_chain_out}, 16'h0001);
    i_host.pulse_strobe();
    #1;
    check(sink_channels, 16'hA5C3);
  endtask
  task automatic t_hold_and_chain();
    i_host.shift_bits(16'h3C96, 16);
    #1;
    check(sink_channels, 16'hA5C3);
    check({15'h0000, serial_chain_out}, 16'h0000);
  endtask
  task automatic t_blank();
    i_host.set_pins(1'b0, 1'b1);
    @(posedge sys_clk);
    #1;
    check(sink_channels, 16'h0000);
    i_host.set_pins(1'b0, 1'b0);
    @(posedge sys_clk);
    #1;
    check(sink_channels, 16'hA5C3);
  endtask
  task automatic t_transparent();
    i_host.set_pins(1'b1, 1'b0);
    @(posedge sys_clk);
    #1;
    check(sink_channels, 16'h3C96);
    i_host.shift_bits(16'h0001, 1);
    #1;
    check(sink_channels, 16'h792D);
  endtask
  task automatic t_clk_en_freeze();
    @(posedge sys_clk);
    clk_en <= 1'b0;
    i_host.shift_bits(16'h0000, 1);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    @(posedge sys_clk);
    #1;
    check(sink_channels, 16'h792D);
  endtask
  task automatic t_modes();
    i_host.enter_mode(1'b0);
    #1;
    check({14'h0000, mode}, 16'h0001);
    check(sink_channels, 16'h0000);
    i_host.set_pins(1'b1, 1'b0);
    @(posedge sys_clk);
    #1;
    check(error_bits, 16'h0068);
    i_host.set_pins(1'b0, 1'b0);
    @(posedge sys_clk);
    #1;
    check({14'h0000, mode}, 16'h0000);
    i_host.enter_mode(1'b1);
    #1;
    check({14'h0000, mode}, 16'h0002);
    i_host.set_pins(1'b0, 1'b1);
    @(posedge sys_clk);
    #1;
    check({14'h0000, mode}, 16'h0000);
    check(error_bits, 16'h0068);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset_state();
    t_load_word();
    t_hold_and_chain();
    t_blank();
    t_transparent();
    t_clk_en_freeze();
    t_modes();
    give_verdict();
  end
endmodule
`default_nettype wire
